//--- dpgr_pkg.sv
/*
 general-register bank package: offsets, field positions, reset values, types.
 assumes a byte-wide dual-port register port on a single 125 MHz clock.
*/
`default_nettype none
package dpgr_pkg;
	localparam logic [7:0] OFF_CMD_ERR = 8'h12;
	localparam logic [7:0] OFF_PRG_ERR = 8'h13;
	localparam logic [7:0] OFF_SAMPLE = 8'h14;
	localparam logic [7:0] OFF_SEGMENT = 8'h18;
	localparam logic [7:0] OFF_FW_REV = 8'h20;
	localparam logic [7:0] OFF_AXIS_COUNT = 8'h26;
	localparam logic [7:0] OFF_ANALOG = 8'h27;
	localparam logic [7:0] OFF_PB_POLICY = 8'h28;
	localparam logic [7:0] OFF_UPD_INT = 8'h29;
	localparam logic [7:0] OFF_INPUT_COPY = 8'h2a;
	localparam logic [7:0] OFF_OUTPUT_PORT = 8'h2b;
	localparam logic [7:0] OFF_INT_CAUSE = 8'h30;
	localparam int SAMPLE_BYTES = 4;
	localparam int SEGMENT_BYTES = 2;
	localparam int FW_BYTES = 6;
	localparam int INT_BYTES = 2;
	localparam logic [7:0] RST_UPD_INT = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] POLICY_DROP_NEW = 2'h0;
	localparam logic [1:0] POLICY_STALL = 2'h1;
	localparam logic [1:0] POLICY_DROP_OLD = 2'h2;
	localparam int INT_INPUTS = 7;
	localparam int INT_CMD_DONE = 6;
	localparam int INT_PRG_STOP = 5;
	localparam int INT_USER = 4;
	localparam int INT_WATCHDOG = 3;
	localparam int INT_LIMIT = 2;
	localparam int INT_POS_ERR = 1;
	localparam int INT_ALL_DONE = 0;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dpgr_req_t;
	typedef struct packed {
		logic cmd_err;
		logic [7:0] cmd_code;
		logic prg_err;
		logic [7:0] prg_code;
		logic [15:0] segment;
	} dpgr_post_t;
	typedef enum {ST_IDLE, ST_POST, ST_STAMP} dpgr_upd_state_t;
endpackage
`default_nettype wire

//--- dpgr_regs.sv
/*
 general-register bank of the dual-port ram: error codes, sample counter,
 ids, i/o copies, program buffer policy, update pacing and interrupt cause.
 assumes the host port and the controller's posting inputs are synchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dpgr_regs #(
	parameter logic [47:0] FW_REVISION = 48'h000000000000, // arbitrary value
	parameter int AXES = 4,
	parameter bit ANALOG_FITTED = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// host dual-port access
	input wire dpgr_pkg::dpgr_req_t host_req,
	output logic [7:0] host_rdata,
	// controller posting side
	input wire logic sample_tick,
	input wire dpgr_pkg::dpgr_post_t post,
	input wire logic [15:0] int_events,
	input wire logic [7:0] input_port,
	output logic [7:0] output_port,
	output logic update_strobe,
	// program buffer flow control
	input wire logic pb_full,
	input wire logic prog_write,
	output logic pb_accept,
	output logic pb_drop_new,
	output logic pb_drop_old,
	output logic prog_stall
);
	if (AXES < 1 || AXES > 4) begin : g_axes_check
		$error("axes must be 1 to 4");
	end

	logic [7:0] cmd_err_reg, prg_err_reg, policy_reg, upd_int_reg;
	logic [7:0] in_copy_reg, out_shadow_reg, out_drive_reg;
	logic [31:0] sample_reg, sample_next;
	logic [15:0] segment_reg, int_cause_reg;
	logic [7:0] upd_cnt_reg;
	logic upd_due;
	dpgr_pkg::dpgr_upd_state_t upd_state;
	logic host_wr;

	assign host_wr = host_req.wr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int n);
		hit = (a >= base) && ({24'h0, a} < {24'h0, base} + n);
	endfunction

	// error codes: new error wins over host clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmd_err_reg <= dpgr_pkg::RST_BYTE;
			prg_err_reg <= dpgr_pkg::RST_BYTE;
		end else begin
			if (post.cmd_err) begin
				cmd_err_reg <= post.cmd_code;
			end else if (host_wr && host_req.addr == dpgr_pkg::OFF_CMD_ERR) begin
				cmd_err_reg <= host_req.wdata;
			end
			if (post.prg_err) begin
				prg_err_reg <= post.prg_code;
			end else if (host_wr && host_req.addr == dpgr_pkg::OFF_PRG_ERR) begin
				prg_err_reg <= host_req.wdata;
			end
		end
	end

	// host control bytes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			policy_reg <= dpgr_pkg::RST_BYTE;
			upd_int_reg <= dpgr_pkg::RST_UPD_INT;
			out_shadow_reg <= dpgr_pkg::RST_BYTE;
		end else if (host_wr) begin
			if (host_req.addr == dpgr_pkg::OFF_PB_POLICY) begin
				policy_reg <= host_req.wdata;
			end else if (host_req.addr == dpgr_pkg::OFF_UPD_INT) begin
				upd_int_reg <= host_req.wdata;
			end else if (host_req.addr == dpgr_pkg::OFF_OUTPUT_PORT) begin
				out_shadow_reg <= host_req.wdata;
			end
		end
	end

	// outputs change only on the next sample
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			out_drive_reg <= dpgr_pkg::RST_BYTE;
			in_copy_reg <= dpgr_pkg::RST_BYTE;
		end else if (sample_tick) begin
			out_drive_reg <= out_shadow_reg;
			in_copy_reg <= input_port;
		end
	end
	assign output_port = out_drive_reg;

	// sample counter, independent of host writes
	assign sample_next = sample_reg + 32'h1;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sample_reg <= 32'h0;
		end else if (sample_tick) begin
			sample_reg <= sample_next;
		end
	end

	// update pacing: interval byte counts pairs of samples up to 128, above that no update is posted; zero means every sample
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			upd_cnt_reg <= 8'h0;
		end else if (sample_tick) begin
			upd_cnt_reg <= upd_due ? 8'h0 : upd_cnt_reg + 8'h1;
		end
	end
	assign upd_due = ({1'b0, upd_cnt_reg} + 9'h1) >= {upd_int_reg, 1'b0};

	// posting sequence: data first, counter stamp last
	logic [31:0] sample_pub_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			upd_state <= dpgr_pkg::ST_IDLE;
			segment_reg <= 16'h0;
			sample_pub_reg <= 32'h0;
		end else begin
			case (upd_state)
				dpgr_pkg::ST_IDLE: begin
					if (sample_tick && upd_due) upd_state <= dpgr_pkg::ST_POST;
				end
				dpgr_pkg::ST_POST: begin
					segment_reg <= post.segment;
					upd_state <= dpgr_pkg::ST_STAMP;
				end
				dpgr_pkg::ST_STAMP: begin
					sample_pub_reg <= sample_reg;
					upd_state <= dpgr_pkg::ST_IDLE;
				end
				default: upd_state <= dpgr_pkg::ST_IDLE;
			endcase
		end
	end
	assign update_strobe = (upd_state == dpgr_pkg::ST_STAMP);

	// interrupt cause: set wins over host clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			int_cause_reg <= 16'h0;
		end else begin
			for (int i = 0; i < dpgr_pkg::INT_BYTES; i++) begin
				if (host_wr && host_req.addr == dpgr_pkg::OFF_INT_CAUSE + 8'(i)) begin
					int_cause_reg[i*8 +: 8] <= (int_cause_reg[i*8 +: 8] & ~host_req.wdata)
						| int_events[i*8 +: 8];
				end else begin
					int_cause_reg[i*8 +: 8] <= int_cause_reg[i*8 +: 8] | int_events[i*8 +: 8];
				end
			end
		end
	end

	// program buffer full policy
	always_comb begin
		pb_accept = prog_write && !pb_full;
		pb_drop_new = 1'b0;
		pb_drop_old = 1'b0;
		prog_stall = 1'b0;
		if (prog_write && pb_full) begin
			case (policy_reg[1:0])
				dpgr_pkg::POLICY_DROP_NEW: pb_drop_new = 1'b1;
				dpgr_pkg::POLICY_STALL: prog_stall = 1'b1;
				dpgr_pkg::POLICY_DROP_OLD: begin
					pb_drop_old = 1'b1;
					pb_accept = 1'b1;
				end
				default: pb_drop_new = 1'b1;
			endcase
		end
	end

	// read mux, registered
	logic [7:0] rd_next;
	logic [7:0] off;
	always_comb begin
		off = host_req.addr;
		rd_next = 8'h00;
		if (off == dpgr_pkg::OFF_CMD_ERR) begin
			rd_next = cmd_err_reg;
		end else if (off == dpgr_pkg::OFF_PRG_ERR) begin
			rd_next = prg_err_reg;
		end else if (hit(off, dpgr_pkg::OFF_SAMPLE, dpgr_pkg::SAMPLE_BYTES)) begin
			rd_next = sample_pub_reg[(off - dpgr_pkg::OFF_SAMPLE) * 8 +: 8];
		end else if (hit(off, dpgr_pkg::OFF_SEGMENT, dpgr_pkg::SEGMENT_BYTES)) begin
			rd_next = segment_reg[(off - dpgr_pkg::OFF_SEGMENT) * 8 +: 8];
		end else if (hit(off, dpgr_pkg::OFF_FW_REV, dpgr_pkg::FW_BYTES)) begin
			rd_next = FW_REVISION[(off - dpgr_pkg::OFF_FW_REV) * 8 +: 8];
		end else if (off == dpgr_pkg::OFF_AXIS_COUNT) begin
			rd_next = 8'(AXES);
		end else if (off == dpgr_pkg::OFF_ANALOG) begin
			rd_next = {7'h0, ANALOG_FITTED};
		end else if (off == dpgr_pkg::OFF_PB_POLICY) begin
			rd_next = policy_reg;
		end else if (off == dpgr_pkg::OFF_UPD_INT) begin
			rd_next = upd_int_reg;
		end else if (off == dpgr_pkg::OFF_INPUT_COPY) begin
			rd_next = in_copy_reg;
		end else if (off == dpgr_pkg::OFF_OUTPUT_PORT) begin
			rd_next = out_drive_reg;
		end else if (hit(off, dpgr_pkg::OFF_INT_CAUSE, dpgr_pkg::INT_BYTES)) begin
			rd_next = int_cause_reg[(off - dpgr_pkg::OFF_INT_CAUSE) * 8 +: 8];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			host_rdata <= 8'h00;
		end else if (host_req.rd) begin
			host_rdata <= rd_next;
		end
	end

	// assertions
	a_cmd_err_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!post.cmd_err && !(host_wr && host_req.addr == dpgr_pkg::OFF_CMD_ERR) |=> $stable(cmd_err_reg))
		else $error("command error code changed without cause");
	a_cmd_err_load: assert property (@(posedge ref_clk) disable iff (srst)
		post.cmd_err |=> cmd_err_reg == $past(post.cmd_code))
		else $error("command error code not captured");
	a_prg_err_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!post.prg_err && !(host_wr && host_req.addr == dpgr_pkg::OFF_PRG_ERR) |=> $stable(prg_err_reg))
		else $error("program error code changed without cause");
	a_prg_err_load: assert property (@(posedge ref_clk) disable iff (srst)
		post.prg_err |=> prg_err_reg == $past(post.prg_code))
		else $error("program error code not captured");
	a_counter_step: assert property (@(posedge ref_clk) disable iff (srst)
		sample_tick |=> sample_reg == $past(sample_reg) + 32'h1)
		else $error("sample counter did not step by one");
	a_counter_clear: assert property (@(posedge ref_clk)
		srst |=> sample_reg == 32'h0)
		else $error("sample counter not cleared by reset");
	a_counter_idle: assert property (@(posedge ref_clk) disable iff (srst)
		!sample_tick |=> $stable(sample_reg))
		else $error("sample counter moved without a tick");
	a_stamp_last: assert property (@(posedge ref_clk) disable iff (srst)
		upd_state == dpgr_pkg::ST_POST |=> update_strobe ##1 $stable(segment_reg))
		else $error("counter stamp not after posting");
	a_stamp_value: assert property (@(posedge ref_clk) disable iff (srst)
		update_strobe |=> sample_pub_reg == $past(sample_reg))
		else $error("published counter not taken at stamp");
	a_segment_post: assert property (@(posedge ref_clk) disable iff (srst)
		upd_state == dpgr_pkg::ST_POST |=> segment_reg == $past(post.segment))
		else $error("segment index not posted");
	a_input_copy: assert property (@(posedge ref_clk) disable iff (srst)
		sample_tick |=> in_copy_reg == $past(input_port))
		else $error("input copy not taken on sample");
	a_output_delay: assert property (@(posedge ref_clk) disable iff (srst)
		!sample_tick |=> $stable(output_port))
		else $error("outputs changed between samples");
	a_drop_new: assert property (@(posedge ref_clk) disable iff (srst)
		prog_write && pb_full && policy_reg == 8'h00 |-> pb_drop_new && !pb_accept)
		else $error("new data not dropped in policy zero");
	a_stall_policy: assert property (@(posedge ref_clk) disable iff (srst)
		prog_write && pb_full && policy_reg == 8'h01 |-> prog_stall && !pb_accept)
		else $error("program not stalled in policy one");
	a_drop_old: assert property (@(posedge ref_clk) disable iff (srst)
		prog_write && pb_full && policy_reg == 8'h02 |-> pb_drop_old && pb_accept)
		else $error("old data not dropped in policy two");
	a_cause_sticky: assert property (@(posedge ref_clk) disable iff (srst)
		int_events[dpgr_pkg::INT_WATCHDOG] |=> int_cause_reg[dpgr_pkg::INT_WATCHDOG])
		else $error("watchdog cause bit not set");
	a_cause_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!int_events[dpgr_pkg::INT_ALL_DONE] && !(host_wr && host_req.addr == dpgr_pkg::OFF_INT_CAUSE)
		|=> $stable(int_cause_reg[dpgr_pkg::INT_ALL_DONE]))
		else $error("cause bit changed without event or clear");
	c_update_cycle: cover property (@(posedge ref_clk) disable iff (srst)
		sample_tick && upd_due ##1 upd_state == dpgr_pkg::ST_POST ##1 update_strobe);
	c_drop_old: cover property (@(posedge ref_clk) disable iff (srst) pb_drop_old);
	c_stall: cover property (@(posedge ref_clk) disable iff (srst) prog_stall);
	c_err_clear: cover property (@(posedge ref_clk) disable iff (srst)
		host_wr && host_req.addr == dpgr_pkg::OFF_CMD_ERR);
	c_cause_clear: cover property (@(posedge ref_clk) disable iff (srst)
		host_wr && host_req.addr == dpgr_pkg::OFF_INT_CAUSE && host_req.wdata != 8'h00);
endmodule
`default_nettype wire

//--- dpgr_host.sv
/*
 host cpu model: byte reads and writes on the dual-port register port.
 assumes the bank takes a request at the rising edge after it is raised.
*/
`timescale 1ns/10ps
`default_nettype none
module dpgr_host (
	// clock
	input wire logic ref_clk,
	// dual-port access
	output var dpgr_pkg::dpgr_req_t host_req,
	input wire logic [7:0] host_rdata
);
	initial host_req = '0;
	// one-cycle write, released data inverted; also used for policy and cause clears
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// one-cycle read, data taken at the falling edge half a cycle after the sampling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge ref_clk);
		host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h00};
		d = host_rdata;
	endtask
endmodule
`default_nettype wire

//--- dual_port_general_regs_tb_top.sv
/*
 self-checking bench for the general-register bank.
 assumes the bank's contract: byte port, read data one cycle after rd.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_port_general_regs_tb_top;
	localparam logic [47:0] FW_ID = 48'h0a0b0c0d0e0f; // arbitrary value
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic sample_tick = 1'b0;
	dpgr_pkg::dpgr_post_t post = '0;
	logic [15:0] int_events = 16'h0000;
	logic [7:0] input_port = 8'h00;
	logic pb_full = 1'b0;
	logic prog_write = 1'b0;
	dpgr_pkg::dpgr_req_t host_req;
	logic [7:0] host_rdata, output_port, d;
	logic update_strobe, pb_accept, pb_drop_new, pb_drop_old, prog_stall;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	always #4 ref_clk = ~ref_clk;
	dpgr_regs #(.FW_REVISION(FW_ID)) dut_u (.ref_clk(ref_clk), .srst(srst), .host_req(host_req), .host_rdata(host_rdata),
		.sample_tick(sample_tick), .post(post), .int_events(int_events), .input_port(input_port),
		.output_port(output_port), .update_strobe(update_strobe), .pb_full(pb_full),
		.prog_write(prog_write), .pb_accept(pb_accept), .pb_drop_new(pb_drop_new),
		.pb_drop_old(pb_drop_old), .prog_stall(prog_stall));
	dpgr_host host_u (.ref_clk(ref_clk), .host_req(host_req), .host_rdata(host_rdata));
	task automatic report_and_stop;
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a, d);
		chk({24'h0, d}, {24'h0, exp});
	endtask
	task automatic tick;
		@(negedge ref_clk);
		sample_tick = 1'b1;
		@(negedge ref_clk);
		sample_tick = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask
	// counter ignores writes, counts ticks, publishes segment and inputs
	task automatic t_counter;
		rchk(8'h14, 8'h00);
		for (int i = 0; i < 4; i++) host_u.wr(8'h14 + i[7:0], 8'hff);
		post.segment = 16'h1234;
		input_port = 8'h82;
		repeat (3) tick();
		for (int i = 0; i < 4; i++) rchk(8'h14 + i[7:0], i == 0 ? 8'h03 : 8'h00);
		rchk(8'h18, 8'h34);
		rchk(8'h19, 8'h12);
		rchk(8'h2a, 8'h82);
	endtask
	// stamp strobe follows posting, counter published last
	task automatic t_stamp;
		@(negedge ref_clk);
		post.segment = 16'h5678;
		sample_tick = 1'b1;
		@(negedge ref_clk);
		sample_tick = 1'b0;
		chk({31'h0, update_strobe}, 32'h0);
		@(negedge ref_clk);
		chk({31'h0, update_strobe}, 32'h1);
		@(negedge ref_clk);
		chk({31'h0, update_strobe}, 32'h0);
		rchk(8'h14, 8'h04);
		rchk(8'h18, 8'h78);
	endtask
	task automatic t_errors;
		@(negedge ref_clk);
		post.cmd_err = 1'b1;
		post.cmd_code = 8'h5a;
		post.prg_err = 1'b1;
		post.prg_code = 8'hc3;
		@(negedge ref_clk);
		post.cmd_err = 1'b0;
		post.prg_err = 1'b0;
		repeat (3) @(negedge ref_clk);
		rchk(8'h12, 8'h5a);
		host_u.wr(8'h12, 8'h00);
		rchk(8'h12, 8'h00);
		rchk(8'h13, 8'hc3);
		rchk(8'h3f, 8'h00);
	endtask
	task automatic t_ids;
		for (int i = 0; i < 6; i++) rchk(8'h20 + i[7:0], FW_ID[i*8 +: 8]);
		host_u.wr(8'h26, 8'h09);
		rchk(8'h26, 8'h04);
		rchk(8'h27, 8'h01);
	endtask
	task automatic t_policy;
		logic [3:0] exp [3] = '{4'b0100, 4'b0001, 4'b1010};
		pb_full = 1'b1;
		prog_write = 1'b1;
		for (int p = 0; p < 3; p++) begin
			host_u.wr(8'h28, p[7:0]);
			rchk(8'h28, p[7:0]);
			chk({28'h0, pb_accept, pb_drop_new, pb_drop_old, prog_stall}, {28'h0, exp[p]});
		end
		pb_full = 1'b0;
		prog_write = 1'b0;
	endtask
	task automatic t_outputs;
		host_u.wr(8'h2b, 8'ha5);
		chk({24'h0, output_port}, 32'h0);
		rchk(8'h2b, 8'h00);
		tick();
		chk({24'h0, output_port}, 32'ha5);
		rchk(8'h2b, 8'ha5);
		host_u.wr(8'h29, 8'h02);
		rchk(8'h29, 8'h02);
		repeat (3) tick();
		rchk(8'h14, 8'h05);
		tick();
		rchk(8'h14, 8'h09);
	endtask
	task automatic t_irq;
		@(negedge ref_clk);
		int_events = 16'h0108;
		@(negedge ref_clk);
		int_events = 16'h0000;
		rchk(8'h30, 8'h08);
		rchk(8'h31, 8'h01);
		host_u.wr(8'h30, 8'h08);
		rchk(8'h30, 8'h00);
		rchk(8'h31, 8'h01);
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		t_counter();
		t_stamp();
		t_errors();
		t_ids();
		t_policy();
		t_outputs();
		t_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
